// ==== mfrm_chk_monitor.sv ====
// Checker on the range monitor ports: bus timing, status layout, flag pins, interrupt mask.
`timescale 1ns/1ns
module mfrm_chk_monitor (
   // Clock and reset.
   input wire logic        sys_clk,
   input wire logic        rst_n,
   // Watched ports.
   input wire logic        sample_valid,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [7:0]  wb_adr_i,
   input wire logic [3:0]  wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        field_high_flag,
   input wire logic        field_low_flag,
   input wire logic        irq
);
   // Code and flags settle at different edges, so flag checks skip reads near a sample.
   logic [2:0] sv_hist_ff;
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) sv_hist_ff <= 3'h0;
      else sv_hist_ff <= {sv_hist_ff[1:0], sample_valid};
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_n);
   sequence rd27_s;
      wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i[7:2]) == 6'h1b;
   endsequence
   ////////////////////////////////////////////////////////////////////////////////
   chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not answered in the next cycle");
   chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without a request");
   chk_stat_layout: assert property (rd27_s |-> wb_dat_o[31:8] == 24'h0 && wb_dat_o[5:4] == 2'h0)
      else $error("status read has stray bits set");
   chk_stat_flags: assert property (rd27_s ##0 sv_hist_ff == 3'h0
      |-> wb_dat_o[7:6] == {field_high_flag, field_low_flag})
      else $error("status flag bits differ from flag pins");
   chk_flag_code: assert property (rd27_s ##0 sv_hist_ff == 3'h0
      |-> wb_dat_o[7] == wb_dat_o[2] && wb_dat_o[6] == !wb_dat_o[0])
      else $error("flag bits disagree with range code");
   chk_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i)
      && !($past(wb_adr_i[7:2]) inside {6'h06, [6'h1b:6'h1e]}) |-> wb_dat_o == 32'h0)
      else $error("unmapped read returned nonzero data");
   chk_mask_irq: assert property (wb_ack_o && $past(wb_we_i && wb_sel_i[0]
      && wb_adr_i[7:2] == 6'h1d && wb_dat_i[2:0] == 3'h0) |=> !irq)
      else $error("interrupt high with all events masked");
   cover property (rd27_s);
   cover property ($rose(irq));
   cover property ($rose(field_high_flag));
endmodule // mfrm_chk_monitor

// ==== mfrm_event_irq.sv ====
// Sticky event status with read-clear, mask and a level interrupt output.
`timescale 1ns/1ns
module mfrm_event_irq #(
   parameter int unsigned W = 3
) (
   // Clock and reset.
   input  wire logic         sys_clk,
   input  wire logic         rst_n,
   // Events and software side.
   input  wire logic [W-1:0] evt,
   input  wire logic         rd_clr,
   input  wire logic [W-1:0] mask,
   // Results.
   output logic [W-1:0]      status_ff,
   output logic              irq
);

   logic [W-1:0] nxt_status;

   // An event in the clearing cycle survives the clear.
   assign nxt_status = (status_ff & ~{W{rd_clr}}) | evt;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         status_ff <= '0;
      end else begin
         status_ff <= nxt_status;
      end
   end

   assign irq = |(status_ff & mask);

endmodule // mfrm_event_irq

// ==== mfrm_host.sv ====
// Host model: Wishbone classic master tasks and range code classification.
`timescale 1ns/1ns
module mfrm_host (
   // Clock.
   input wire logic         sys_clk,
   // Master side, named after the slave pins they feed.
   output logic             wb_cyc_i,
   output logic             wb_stb_i,
   output logic             wb_we_i,
   output logic [7:0]       wb_adr_i,
   output logic [3:0]       wb_sel_i,
   output logic [31:0]      wb_dat_i,
   input  wire logic [31:0] wb_dat_o,
   input  wire logic        wb_ack_o
);
   initial begin
      wb_cyc_i = 1'b0;
      wb_stb_i = 1'b0;
      wb_we_i  = 1'b0;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'h0;
      wb_dat_i = 32'h0;
   end
   // Holds the request until the rising edge that samples ack high, takes the data
   // there and releases at that same edge. Flop outputs read right after the edge
   // still hold the values sampled at it.
   task automatic xfer(output logic [31:0] d);
      @(posedge sys_clk);
      while (wb_ack_o !== 1'b1) @(posedge sys_clk);
      d = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i  <= 1'b0;
   endtask
   task automatic acc(input logic w, input logic [5:0] idx, input logic [7:0] v,
                      input logic [3:0] s, output logic [31:0] d);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i  <= w;
      wb_adr_i <= {idx, 2'b00};
      wb_sel_i <= s;
      wb_dat_i <= {24'h0, v};
      xfer(d);
   endtask
   // Anything but the three valid codes is treated as a sensor fault.
   function automatic logic is_fault(input logic [3:0] c);
      return !(c inside {4'h3, 4'hf, 4'h0});
   endfunction
endmodule // mfrm_host

// ==== mfrm_level_cmp.sv ====
// Field level comparator with release hysteresis for one channel and one threshold.
`timescale 1ns/1ns
module mfrm_level_cmp (
   // Clock and reset.
   input  wire logic                              sys_clk,
   input  wire logic                              rst_n,
   // Sample and threshold.
   input  wire logic                              sample_valid,
   input  wire logic [mfrm_pkg::FIELD_W-1:0]      field,
   input  wire logic [mfrm_pkg::FIELD_W-1:0]      level,
   // Result.
   output logic                                   above_ff
);

   logic [mfrm_pkg::FIELD_W-1:0] release_level;
   logic                         nxt_above;

   // Saturate so a small level never wraps into a huge release point.
   assign release_level = (level > mfrm_pkg::HYST_MT) ? level - mfrm_pkg::HYST_MT
                                                      : '0;

   // Hysteresis keeps noise near a threshold from toggling the result each sample.
   always_comb begin
      nxt_above = above_ff;
      if (field >= level) begin
         nxt_above = 1'b1;
      end else if (field < release_level) begin
         nxt_above = 1'b0;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         above_ff <= 1'b0;
      end else if (sample_valid) begin
         above_ff <= nxt_above;
      end
   end

endmodule // mfrm_level_cmp

// ==== mfrm_monitor.sv ====
// Magnetic field range monitor: thresholds, range code, flags, registers, interrupt.
//
// Overview of operation
// - A 4-bit field range code sits in status register 27.
// - Low and high thresholds each come from a 3-bit field of register 6.
// - Field between thresholds gives code 0011, also meaning front end acquires.
// - Field above both thresholds, magnet too close, gives code 1111.
// - Field below both thresholds, magnet far or absent, gives code 0000.
// - Other table codes appear only when the Hall array has a functional error; here they also appear when low is set above high.
// - Reset selects low threshold 15mT and high threshold 111, 126mT.
// - High flag at bit 7, low flag at bit 6, both also on pins.
// - A read addressed to register 27 returns its contents in that transfer.
//
// Register map; the byte address is four times the index, data sits in byte lane 0.
//   Index 6: [7:5] high select, [4:2] low select, [1:0] spare storage.
//   Index 27: [7] high flag, [6] low flag, [5:4] zero, [3:0] range code.
//   Index 28: [0] code changed, [1] invalid code, [2] sample stall; a read clears it.
//   Index 29: interrupt mask [2:0]; a one lets the matching event drive irq.
//   Index 30: [0] stalled, no sample seen for the whole watchdog period.
// Unmapped indices read as zero and ignore writes, and every request is acked.
//
// Local design decisions: the Wishbone slave port and the address map.
`timescale 1ns/1ns
module mfrm_monitor (
   // Clock and reset.
   input  wire logic                              sys_clk,
   input  wire logic                              rst_n,
   // Hall front end samples, one per channel.
   input  wire logic                              sample_valid,
   input  wire logic [mfrm_pkg::FIELD_W-1:0]      field_a,
   input  wire logic [mfrm_pkg::FIELD_W-1:0]      field_b,
   // Wishbone slave.
   input  wire logic                              wb_cyc_i,
   input  wire logic                              wb_stb_i,
   input  wire logic                              wb_we_i,
   input  wire logic [mfrm_pkg::ADR_W-1:0]        wb_adr_i,
   input  wire logic [3:0]                        wb_sel_i,
   input  wire logic [31:0]                       wb_dat_i,
   output logic [31:0]                            wb_dat_o,
   output logic                                   wb_ack_o,
   // Flag pins and interrupt.
   output logic                                   field_high_flag,
   output logic                                   field_low_flag,
   output logic                                   irq
);

   ////////////////////////////////////////////////////////////////////////////////
   // Declarations.
   // Registers first, then the threshold path, then events and the bus side.
   logic [7:0]                              thresh_ff;
   logic [mfrm_pkg::EVT_W-1:0]              irq_mask_ff;
   logic [mfrm_pkg::CODE_W-1:0]             range_code_ff;
   logic [mfrm_pkg::CODE_W-1:0]             nxt_code;
   logic                                    sample_d_ff;
   logic                                    stalled_ff;
   logic [mfrm_pkg::TMO_W-1:0]              tmo_cnt_ff;
   logic                                    tmo_hit;
   logic                                    ack_ff;
   logic [31:0]                             rdata_ff;
   logic                                    high_flag_ff;
   logic                                    low_flag_ff;

   // Threshold and comparator path.
   logic [mfrm_pkg::SEL_W-1:0]              low_field_threshold_sel;
   logic [mfrm_pkg::SEL_W-1:0]              high_field_threshold_sel;
   logic [mfrm_pkg::FIELD_W-1:0]            low_field_level;
   logic [mfrm_pkg::FIELD_W-1:0]            high_field_level;
   logic [1:0]                              above_low;
   logic [1:0]                              above_high;
   logic [mfrm_pkg::FIELD_W-1:0]            ch_field [2];

   // Events and bus side.
   logic [mfrm_pkg::EVT_W-1:0]              evt;
   logic [mfrm_pkg::EVT_W-1:0]              irq_status;
   logic                                    req;
   logic                                    access;
   logic [mfrm_pkg::ADR_W-1:0]              idx;
   logic                                    code_valid;
   logic                                    fault_code;
   logic [31:0]                             nxt_rdata;
   logic                                    wr_en;
   logic                                    wr_thresh;
   logic                                    wr_mask;
   logic                                    rd_irq_clr;
   logic                                    stall_evt;

   ////////////////////////////////////////////////////////////////////////////////
   // Threshold selection.
   // Low may be set above high; the code then reports what the comparators see.
   assign low_field_threshold_sel  = thresh_ff[mfrm_pkg::THR_LOW_LSB +: mfrm_pkg::SEL_W];
   assign high_field_threshold_sel = thresh_ff[mfrm_pkg::THR_HIGH_LSB +: mfrm_pkg::SEL_W];
   assign low_field_level  = mfrm_pkg::LEVEL_MT[low_field_threshold_sel];
   assign high_field_level = mfrm_pkg::LEVEL_MT[high_field_threshold_sel];

   // Channel A alone drives the flag pins; channel B only takes part in the code.
   assign ch_field[0] = field_a;
   assign ch_field[1] = field_b;

   ////////////////////////////////////////////////////////////////////////////////
   // Comparators: each of the two Hall channels is checked against both levels.
   // Channels disagreeing, or a channel above high but not above low, come from a
   // broken array or from low set above high, which is how invalid codes arise.
   for (genvar ch = 0; ch < 2; ch++) begin : g_ch
      mfrm_level_cmp u_low (
         .sys_clk      (sys_clk),
         .rst_n        (rst_n),
         .sample_valid (sample_valid),
         .field        (ch_field[ch]),
         .level        (low_field_level),
         .above_ff     (above_low[ch])
      );
      mfrm_level_cmp u_high (
         .sys_clk      (sys_clk),
         .rst_n        (rst_n),
         .sample_valid (sample_valid),
         .field        (ch_field[ch]),
         .level        (high_field_level),
         .above_ff     (above_high[ch])
      );
   end

   // Code layout: high channel B, high channel A, low channel B, low channel A.
   assign nxt_code = {above_high[1], above_high[0], above_low[1], above_low[0]};

   // Health is judged on the code being loaded, so the fault event lands on the
   // same edge as the code it reports. Unlisted patterns count as faults too.
   always_comb begin
      code_valid = 1'b0;
      case (nxt_code)
         mfrm_pkg::CODE_IN_RANGE: begin
            code_valid = 1'b1;
         end
         mfrm_pkg::CODE_TOO_CLOSE: begin
            code_valid = 1'b1;
         end
         mfrm_pkg::CODE_TOO_FAR: begin
            code_valid = 1'b1;
         end
         default: begin
            code_valid = 1'b0;
         end
      endcase
   end
   assign fault_code = ~code_valid;

   ////////////////////////////////////////////////////////////////////////////////
   // Sample watchdog. If the front end stops acquiring, the code falls to 0000
   // so that 0011 is never left standing from stale samples.
   assign tmo_hit = (tmo_cnt_ff == mfrm_pkg::TMO_W'(mfrm_pkg::SAMPLE_TIMEOUT_CYC - 1));
   // The counter parks at its last count, so a gap raises the stall event once.
   assign stall_evt = tmo_hit && !stalled_ff;

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         tmo_cnt_ff <= '0;
      end else if (sample_valid) begin
         tmo_cnt_ff <= '0;
      end else if (!tmo_hit) begin
         tmo_cnt_ff <= tmo_cnt_ff + 1'b1;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         stalled_ff <= 1'b0;
      end else if (sample_valid) begin
         stalled_ff <= 1'b0;
      end else if (tmo_hit) begin
         stalled_ff <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Range code register, loaded one cycle after each sample.
   // All four comparator bits are taken together on the edge after the sample.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sample_d_ff <= 1'b0;
      end else begin
         sample_d_ff <= sample_valid;
      end
   end

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         range_code_ff <= mfrm_pkg::CODE_TOO_FAR;
      end else if (sample_d_ff) begin
         range_code_ff <= nxt_code;
      end else if (stall_evt) begin
         range_code_ff <= mfrm_pkg::CODE_TOO_FAR;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Alarm flags follow channel A, registered for the pins.
   // The pins trail the code by one edge, so a status read right after a sample
   // may show flags that still belong to the previous code.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         high_flag_ff <= 1'b0;
         low_flag_ff  <= 1'b1;
      end else begin
         high_flag_ff <= range_code_ff[2];
         low_flag_ff  <= ~range_code_ff[0];
      end
   end

   assign field_high_flag = high_flag_ff;
   assign field_low_flag  = low_flag_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt events.
   assign evt[mfrm_pkg::EVT_CHANGE_BIT] = sample_d_ff && (nxt_code != range_code_ff);
   assign evt[mfrm_pkg::EVT_FAULT_BIT]  = sample_d_ff && fault_code;
   assign evt[mfrm_pkg::EVT_STALL_BIT]  = stall_evt;

   ////////////////////////////////////////////////////////////////////////////////
   // Wishbone slave. Ack rises one cycle after the request and drops the next;
   // writes and read side effects happen on the edge where the master sees ack.
   // A master that keeps its request up is acked again every other cycle.
   assign req    = wb_cyc_i && wb_stb_i;
   assign access = req && ack_ff;
   assign idx    = {2'b00, wb_adr_i[mfrm_pkg::ADR_W-1:mfrm_pkg::IDX_LSB]};

   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         ack_ff <= 1'b0;
      end else begin
         ack_ff <= req && !ack_ff;
      end
   end

   assign wb_ack_o = ack_ff;

   // Only byte lane 0 carries register bits: a write without it is acked and dropped.
   assign wr_en      = access && wb_we_i && wb_sel_i[0];
   assign wr_thresh  = wr_en && (idx == mfrm_pkg::REG_THRESH_IDX);
   assign wr_mask    = wr_en && (idx == mfrm_pkg::REG_IRQ_MASK_IDX);
   assign rd_irq_clr = access && !wb_we_i && (idx == mfrm_pkg::REG_IRQ_STAT_IDX);

   // Threshold writes take effect at once; the code follows at the next sample.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         thresh_ff <= mfrm_pkg::THRESH_RST;
      end else if (wr_thresh) begin
         thresh_ff <= wb_dat_i[7:0];
      end
   end

   // The mask resets to zero, so irq stays low until software opts in.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         irq_mask_ff <= mfrm_pkg::IRQ_MASK_RST;
      end else if (wr_mask) begin
         irq_mask_ff <= wb_dat_i[mfrm_pkg::EVT_W-1:0];
      end
   end

   // Read data is captured with the ack; unmapped indices read as zero.
   always_comb begin
      nxt_rdata = '0;
      if (idx == mfrm_pkg::REG_THRESH_IDX) begin
         nxt_rdata[7:0] = thresh_ff;
      end else if (idx == mfrm_pkg::REG_STATUS_IDX) begin
         nxt_rdata[mfrm_pkg::STAT_HIGH_FLAG_BIT] = high_flag_ff;
         nxt_rdata[mfrm_pkg::STAT_LOW_FLAG_BIT]  = low_flag_ff;
         nxt_rdata[mfrm_pkg::CODE_W-1:0]         = range_code_ff;
      end else if (idx == mfrm_pkg::REG_IRQ_STAT_IDX) begin
         nxt_rdata[mfrm_pkg::EVT_W-1:0] = irq_status;
      end else if (idx == mfrm_pkg::REG_IRQ_MASK_IDX) begin
         nxt_rdata[mfrm_pkg::EVT_W-1:0] = irq_mask_ff;
      end else if (idx == mfrm_pkg::REG_FRONT_IDX) begin
         nxt_rdata[0] = stalled_ff;
      end
   end

   // Taken on the request edge, the data stands with ack and holds until the next read.
   always_ff @(posedge sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         rdata_ff <= '0;
      end else if (req && !ack_ff && !wb_we_i) begin
         rdata_ff <= nxt_rdata;
      end
   end

   assign wb_dat_o = rdata_ff;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt status, cleared by a completed read of its register.
   // Masking only gates irq; the status bits keep recording every event.
   mfrm_event_irq #(
      .W (mfrm_pkg::EVT_W)
   ) u_irq (
      .sys_clk   (sys_clk),
      .rst_n     (rst_n),
      .evt       (evt),
      .rd_clr    (rd_irq_clr),
      .mask      (irq_mask_ff),
      .status_ff (irq_status),
      .irq       (irq)
   );

endmodule // mfrm_monitor

// ==== mfrm_pkg.sv ====
// Shared constants for the magnetic field range monitor.
package mfrm_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // Clock and timing.
   localparam int unsigned CLK_PERIOD_NS      = 10;
   localparam int unsigned SAMPLE_TIMEOUT_NS  = 10000;
   localparam int unsigned SAMPLE_TIMEOUT_CYC =
      (SAMPLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned TMO_W              = 11;

   ////////////////////////////////////////////////////////////////////////////////
   // Register indices; the byte address is four times the index.
   localparam logic [7:0] REG_THRESH_IDX   = 8'h06;
   localparam logic [7:0] REG_STATUS_IDX   = 8'h1b;
   localparam logic [7:0] REG_IRQ_STAT_IDX = 8'h1c;
   localparam logic [7:0] REG_IRQ_MASK_IDX = 8'h1d;
   localparam logic [7:0] REG_FRONT_IDX    = 8'h1e;
   localparam int unsigned ADR_W           = 8;
   localparam int unsigned IDX_LSB         = 2;

   ////////////////////////////////////////////////////////////////////////////////
   // Threshold register layout and reset value.
   localparam int unsigned THR_HIGH_LSB = 5;
   localparam int unsigned THR_LOW_LSB  = 2;
   localparam int unsigned SEL_W        = 3;
   localparam logic [7:0]  THRESH_RST   = 8'he0;

   ////////////////////////////////////////////////////////////////////////////////
   // Status register layout.
   localparam int unsigned STAT_HIGH_FLAG_BIT = 7;
   localparam int unsigned STAT_LOW_FLAG_BIT  = 6;
   localparam int unsigned CODE_W             = 4;

   ////////////////////////////////////////////////////////////////////////////////
   // Range codes.
   localparam logic [3:0] CODE_IN_RANGE  = 4'h3;
   localparam logic [3:0] CODE_TOO_CLOSE = 4'hf;
   localparam logic [3:0] CODE_TOO_FAR   = 4'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Interrupt events.
   localparam int unsigned EVT_W          = 3;
   localparam int unsigned EVT_CHANGE_BIT = 0;
   localparam int unsigned EVT_FAULT_BIT  = 1;
   localparam int unsigned EVT_STALL_BIT  = 2;
   localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

   ////////////////////////////////////////////////////////////////////////////////
   // Field levels in mT for each threshold selection, and release hysteresis.
   localparam int unsigned FIELD_W = 8;
   localparam logic [7:0] LEVEL_MT [8] = '{
      8'h0f, 8'h1e, 8'h2d, 8'h3c, 8'h4b, 8'h62, 8'h70, 8'h7e
   };
   localparam logic [7:0] HYST_MT = 8'h06;

endpackage // mfrm_pkg

// ==== tb.sv ====
// Self-checking bench for the magnetic field range monitor.
`timescale 1ns/1ns
module tb;
   logic        sys_clk, rst_n, sample_valid;
   logic [7:0]  field_a, field_b, wb_adr_i;
   logic        wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [3:0]  wb_sel_i;
   logic [31:0] wb_dat_i, wb_dat_o, rd_q;
   logic        field_high_flag, field_low_flag, irq;
   int          miscompares, n_compared, cycles;
   mfrm_monitor mfrm_monitor_i (.sys_clk, .rst_n, .sample_valid, .field_a, .field_b,
      .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o,
      .wb_ack_o, .field_high_flag, .field_low_flag, .irq);
   mfrm_host mfrm_host_i (.sys_clk, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o);
   ////////////////////////////////////////////////////////////////////////////////
   task automatic summarize();
      $display("compared %0d, miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic rchk(input logic [5:0] idx, input logic [31:0] e);
      logic [31:0] d;
      mfrm_host_i.acc(1'b0, idx, 8'h00, 4'hf, d);
      chk(d, e);
   endtask
   task automatic wr(input logic [5:0] idx, input logic [7:0] v, input logic [3:0] s);
      mfrm_host_i.acc(1'b1, idx, v, s, rd_q);
   endtask
   // Pins are looked at mid-cycle, after read-clear updates have landed.
   task automatic pchk(input logic [2:0] e);
      @(negedge sys_clk);
      chk({29'h0, irq, field_high_flag, field_low_flag}, {29'h0, e});
   endtask
   // One sample pulse, then room for the code and flag pipeline to settle.
   task automatic samp(input logic [7:0] a, input logic [7:0] b);
      @(posedge sys_clk);
      sample_valid <= 1'b1;
      field_a <= a;
      field_b <= b;
      @(posedge sys_clk);
      sample_valid <= 1'b0;
      repeat (4) @(posedge sys_clk);
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      cycles++;
      if (cycles == 4000) begin
         miscompares++;
         summarize();
      end
   end
   initial begin
      {rst_n, sample_valid, field_a, field_b} = '0;
      repeat (6) @(posedge sys_clk);
      rst_n <= 1'b1;
      rchk(6'h06, 32'he0);
      rchk(6'h1b, 32'h40);
      pchk(3'b001);
      samp(8'd50, 8'd50);
      rchk(6'h1b, 32'h03);
      pchk(3'b000);
      samp(8'd130, 8'd130);
      rchk(6'h1b, 32'h8f);
      pchk(3'b010);
      samp(8'd5, 8'd5);
      rchk(6'h1b, 32'h40);
      wr(6'h1c, 8'h00, 4'h1);
      rchk(6'h1c, 32'h1);
      wr(6'h1d, 8'h02, 4'h1);
      rchk(6'h1d, 32'h2);
      samp(8'd50, 8'd5);
      rchk(6'h1b, 32'h01);
      chk({31'h0, mfrm_host_i.is_fault(4'h1)}, 32'h1);
      pchk(3'b100);
      rchk(6'h1c, 32'h03);
      pchk(3'b000);
      samp(8'd5, 8'd50);
      rchk(6'h1b, 32'h42);
      pchk(3'b101);
      wr(6'h1d, 8'h00, 4'h1);
      pchk(3'b001);
      wr(6'h06, 8'h04, 4'h1);
      rchk(6'h06, 32'h04);
      samp(8'd20, 8'd20);
      rchk(6'h1b, 32'hcc);
      pchk(3'b011);
      wr(6'h06, 8'he0, 4'he);
      rchk(6'h06, 32'h04);
      wr(6'h1b, 8'hff, 4'h1);
      rchk(6'h1b, 32'hcc);
      rchk(6'h3f, 32'h0);
      wr(6'h06, 8'he0, 4'h1);
      repeat (1010) @(posedge sys_clk);
      rchk(6'h1e, 32'h1);
      rchk(6'h1b, 32'h40);
      rchk(6'h1c, 32'h7);
      summarize();
   end
endmodule // tb

bind mfrm_monitor mfrm_chk_monitor mfrm_chk_monitor_i (.sys_clk, .rst_n, .sample_valid,
   .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
   .field_high_flag, .field_low_flag, .irq);
